//--- logic/apd_top.sv
// Analog power-down configuration register bank
`timescale 1ns/1ps
module apd_top (
    // Clock, reset, enable
    input  wire logic        CLK_IN,
    input  wire logic        RST_IN,
    input  wire logic        CE_IN,

    // Register port
    input  wire logic [11:0] ADDR_IN,
    input  wire logic [31:0] WDATA_IN,
    input  wire logic        WR_IN,
    input  wire logic        RD_IN,
    output logic      [31:0] RDATA_OUT,

    // Processor mode
    input  wire logic        DEEP_SLEEP_IN,

    // Power-down levels, high means powered down
    output logic             INTERNAL_OSC_OFF_OUT,
    output logic             TEMP_SENSOR_OFF_OUT,
    output logic             BROWNOUT_RESET_OFF_OUT,
    output logic             BROWNOUT_IRQ_OFF_OUT,
    output logic             CONVERTER_OFF_OUT,
    output logic             RAM_BANK_A_OFF_OUT,
    output logic             RAM_BANK_B_OFF_OUT,
    output logic             RAM_BANK_C_OFF_OUT,
    output logic             RAM_BANK_X_OFF_OUT,
    output logic             BOOT_ROM_OFF_OUT,
    output logic             CONVERTER_SUPPLY_OFF_OUT,
    output logic             WATCHDOG_OSC_OFF_OUT,
    output logic             USB_PINS_OFF_OUT,
    output logic             MAIN_PLL_OFF_OUT,
    output logic             CONVERTER_REFERENCE_OFF_OUT,

    // Whole word in force, and converter readiness
    output logic      [31:0] POWER_DOWN_OUT,
    output logic             CONVERTER_READY_OUT
);

    // Address decode
    function automatic apd_pkg::apd_reg_t decode_addr(input logic [11:0] addr);
        apd_pkg::apd_reg_t sel;
        sel = apd_pkg::REG_NONE;
        unique case (addr)
            apd_pkg::OFS_DEEP_SLEEP_CFG: sel = apd_pkg::REG_DEEP_SLEEP_CFG;
            apd_pkg::OFS_RUN_CFG:        sel = apd_pkg::REG_RUN_CFG;
            apd_pkg::OFS_RUN_CFG_SET:    sel = apd_pkg::REG_RUN_CFG_SET;
            apd_pkg::OFS_RUN_CFG_CLEAR:  sel = apd_pkg::REG_RUN_CFG_CLEAR;
            apd_pkg::OFS_ACTIVE_STATE:   sel = apd_pkg::REG_ACTIVE_STATE;
            default:                     sel = apd_pkg::REG_NONE;
        endcase
        return sel;
    endfunction : decode_addr

    // Converter may run only with core, supply and reference all powered
    function automatic logic conv_ready(input logic [31:0] word);
        logic ready;
        ready = ~word[apd_pkg::POS_CONVERTER]
              & ~word[apd_pkg::POS_CONV_SUPPLY]
              & ~word[apd_pkg::POS_CONV_REF];
        return ready;
    endfunction : conv_ready

    // Keep only the implemented positions of the run layout
    function automatic logic [31:0] impl_bits(input logic [31:0] word);
        logic [31:0] kept;
        kept = word & apd_pkg::IMPL_MASK;
        return kept;
    endfunction : impl_bits

    // Word in force for the processor mode, as the selector forms it
    function automatic logic [31:0] mode_word(
        input logic [31:0] run,
        input logic [31:0] deep,
        input logic        asleep
    );
        logic [31:0] word;
        if (asleep)
        begin
            word = impl_bits(deep);
        end
        else
        begin
            word = impl_bits(run);
        end
        return word;
    endfunction : mode_word

    // Active-state readback: word in force, mode flag on top
    function automatic logic [31:0] state_word(
        input logic [31:0] word,
        input logic        asleep
    );
        logic [31:0] res;
        res = word;
        res[apd_pkg::POS_STATE_DEEP] = asleep;
        return res;
    endfunction : state_word

    // Internal signals
    apd_cfg_if              cfg_bus ();
    apd_pkg::apd_reg_t      wr_sel;
    apd_pkg::apd_reg_t      rd_sel;
    logic                   wr_en;
    logic                   rd_en;
    logic [31:0]            run_cfg_r;
    logic [31:0]            run_cfg_nxt;
    logic [31:0]            deep_cfg_r;
    logic [31:0]            deep_cfg_nxt;
    logic                   deep_sleep_r;
    logic [31:0]            rdata_r;
    logic [31:0]            rdata_nxt;
    logic [31:0]            active_word;
    logic                   ready_r;
    logic                   ready_nxt;

    assign wr_en  = WR_IN & CE_IN;
    assign rd_en  = RD_IN & CE_IN;
    assign wr_sel = decode_addr(ADDR_IN);
    assign rd_sel = wr_sel;

    // Run word update: direct write, set or clear
    always_comb
    begin
        run_cfg_nxt = run_cfg_r;
        if (wr_en)
        begin
            unique case (wr_sel)
                apd_pkg::REG_RUN_CFG:
                begin
                    run_cfg_nxt = impl_bits(WDATA_IN);
                end
                apd_pkg::REG_RUN_CFG_SET:
                begin
                    run_cfg_nxt = run_cfg_r | impl_bits(WDATA_IN);
                end
                apd_pkg::REG_RUN_CFG_CLEAR:
                begin
                    run_cfg_nxt = run_cfg_r & ~impl_bits(WDATA_IN);
                end
                default:
                begin
                    run_cfg_nxt = run_cfg_r;
                end
            endcase
        end
    end

    // Run word; reset holds each block's documented start state
    always_ff @(posedge CLK_IN)
    begin
        if (RST_IN)
        begin
            run_cfg_r <= apd_pkg::RUN_CFG_RESET;
        end
        else if (CE_IN)
        begin
            run_cfg_r <= run_cfg_nxt;
        end
    end

    // Deep-sleep word, all bits stored as written
    always_comb
    begin
        deep_cfg_nxt = deep_cfg_r;
        if (wr_en && (wr_sel == apd_pkg::REG_DEEP_SLEEP_CFG))
        begin
            deep_cfg_nxt = WDATA_IN;
        end
    end

    always_ff @(posedge CLK_IN)
    begin
        if (RST_IN)
        begin
            deep_cfg_r <= apd_pkg::DEEP_CFG_RESET;
        end
        else if (CE_IN)
        begin
            deep_cfg_r <= deep_cfg_nxt;
        end
    end

    // Processor mode, registered once
    always_ff @(posedge CLK_IN)
    begin
        if (RST_IN)
        begin
            deep_sleep_r <= 1'b0;
        end
        else if (CE_IN)
        begin
            deep_sleep_r <= DEEP_SLEEP_IN;
        end
    end

    // Read mux
    always_comb
    begin
        rdata_nxt = apd_pkg::ZERO_WORD;
        unique case (rd_sel)
            apd_pkg::REG_DEEP_SLEEP_CFG:
            begin
                rdata_nxt = deep_cfg_r;
            end
            apd_pkg::REG_RUN_CFG:
            begin
                rdata_nxt = run_cfg_r;
            end
            apd_pkg::REG_RUN_CFG_SET:
            begin
                rdata_nxt = apd_pkg::ZERO_WORD;
            end
            apd_pkg::REG_RUN_CFG_CLEAR:
            begin
                rdata_nxt = apd_pkg::ZERO_WORD;
            end
            apd_pkg::REG_ACTIVE_STATE:
            begin
                rdata_nxt = state_word(active_word, deep_sleep_r);
            end
            default:
            begin
                rdata_nxt = apd_pkg::ZERO_WORD;
            end
        endcase
    end

    // Read data valid only in the cycle after the strobe
    always_ff @(posedge CLK_IN)
    begin
        if (RST_IN)
        begin
            rdata_r <= apd_pkg::ZERO_WORD;
        end
        else if (CE_IN)
        begin
            if (rd_en)
            begin
                rdata_r <= rdata_nxt;
            end
            else
            begin
                rdata_r <= apd_pkg::ZERO_WORD;
            end
        end
    end

    assign RDATA_OUT = rdata_r;

    // Mode-dependent word selection
    assign cfg_bus.run_cfg    = run_cfg_r;
    assign cfg_bus.deep_cfg   = deep_cfg_r;
    assign cfg_bus.deep_sleep = deep_sleep_r;
    assign active_word        = cfg_bus.active_cfg;

    apd_sel u_sel (
        .clk_in (CLK_IN),
        .rst_in (RST_IN),
        .ce_in  (CE_IN),
        .cfg    (cfg_bus.sel)
    );

    // Readiness registered beside the selector's word, so both move together
    assign ready_nxt = conv_ready(mode_word(run_cfg_r, deep_cfg_r, deep_sleep_r));

    always_ff @(posedge CLK_IN)
    begin
        if (RST_IN)
        begin
            ready_r <= conv_ready(apd_pkg::RUN_CFG_RESET);
        end
        else if (CE_IN)
        begin
            ready_r <= ready_nxt;
        end
    end

    // Per-block levels from the word in force
    assign INTERNAL_OSC_OFF_OUT        = active_word[apd_pkg::POS_INTERNAL_OSC];
    assign TEMP_SENSOR_OFF_OUT         = active_word[apd_pkg::POS_TEMP_SENSOR];
    assign BROWNOUT_RESET_OFF_OUT      = active_word[apd_pkg::POS_BROWNOUT_RST];
    assign BROWNOUT_IRQ_OFF_OUT        = active_word[apd_pkg::POS_BROWNOUT_IRQ];
    assign CONVERTER_OFF_OUT           = active_word[apd_pkg::POS_CONVERTER];
    assign RAM_BANK_A_OFF_OUT          = active_word[apd_pkg::POS_RAM_BANK_A];
    assign RAM_BANK_B_OFF_OUT          = active_word[apd_pkg::POS_RAM_BANK_B];
    assign RAM_BANK_C_OFF_OUT          = active_word[apd_pkg::POS_RAM_BANK_C];
    assign RAM_BANK_X_OFF_OUT          = active_word[apd_pkg::POS_RAM_BANK_X];
    assign BOOT_ROM_OFF_OUT            = active_word[apd_pkg::POS_BOOT_ROM];
    assign CONVERTER_SUPPLY_OFF_OUT    = active_word[apd_pkg::POS_CONV_SUPPLY];
    assign WATCHDOG_OSC_OFF_OUT        = active_word[apd_pkg::POS_WATCHDOG_OSC];
    assign USB_PINS_OFF_OUT            = active_word[apd_pkg::POS_USB_PINS];
    assign MAIN_PLL_OFF_OUT            = active_word[apd_pkg::POS_MAIN_PLL];
    assign CONVERTER_REFERENCE_OFF_OUT = active_word[apd_pkg::POS_CONV_REF];
    assign POWER_DOWN_OUT              = active_word;
    assign CONVERTER_READY_OUT         = ready_r;

endmodule : apd_top

//--- logic/apd_pkg.sv
// Constants and types of the analog power-down configuration bank
package apd_pkg;

    localparam int unsigned ADDR_W = 12;
    localparam int unsigned DATA_W = 32;

    // Register byte offsets
    localparam logic [11:0] OFS_DEEP_SLEEP_CFG = 12'h600;
    localparam logic [11:0] OFS_RUN_CFG        = 12'h610;
    localparam logic [11:0] OFS_RUN_CFG_SET    = 12'h620;
    localparam logic [11:0] OFS_RUN_CFG_CLEAR  = 12'h630;
    localparam logic [11:0] OFS_ACTIVE_STATE   = 12'h640;

    // Field positions, shared by run and deep-sleep layouts
    localparam int unsigned POS_INTERNAL_OSC  = 4;
    localparam int unsigned POS_TEMP_SENSOR   = 6;
    localparam int unsigned POS_BROWNOUT_RST  = 7;
    localparam int unsigned POS_BROWNOUT_IRQ  = 8;
    localparam int unsigned POS_CONVERTER     = 10;
    localparam int unsigned POS_RAM_BANK_A    = 13;
    localparam int unsigned POS_RAM_BANK_B    = 14;
    localparam int unsigned POS_RAM_BANK_C    = 15;
    localparam int unsigned POS_RAM_BANK_X    = 16;
    localparam int unsigned POS_BOOT_ROM      = 17;
    localparam int unsigned POS_CONV_SUPPLY   = 19;
    localparam int unsigned POS_WATCHDOG_OSC  = 20;
    localparam int unsigned POS_USB_PINS      = 21;
    localparam int unsigned POS_MAIN_PLL      = 22;
    localparam int unsigned POS_CONV_REF      = 23;
    localparam int unsigned POS_STATE_DEEP    = 31;

    // Implemented bits of the run layout
    localparam logic [31:0] IMPL_MASK        = 32'h00FB_E5D0;
    // Reset values
    localparam logic [31:0] RUN_CFG_RESET    = 32'h00F8_0540;
    localparam logic [31:0] DEEP_CFG_RESET   = 32'h02F8_0540;
    localparam logic [31:0] ZERO_WORD        = 32'h0000_0000;

    // Register selected by a bus address
    typedef enum logic [2:0] {
        REG_NONE,
        REG_DEEP_SLEEP_CFG,
        REG_RUN_CFG,
        REG_RUN_CFG_SET,
        REG_RUN_CFG_CLEAR,
        REG_ACTIVE_STATE
    } apd_reg_t;

endpackage : apd_pkg

//--- logic/apd_cfg_if.sv
// Configuration words passed from the register file to the output selector
`timescale 1ns/1ps
interface apd_cfg_if;
    logic [31:0] run_cfg;
    logic [31:0] deep_cfg;
    logic        deep_sleep;
    logic [31:0] active_cfg;

    modport regs (
        output run_cfg,
        output deep_cfg,
        output deep_sleep,
        input  active_cfg
    );

    modport sel (
        input  run_cfg,
        input  deep_cfg,
        input  deep_sleep,
        output active_cfg
    );
endinterface : apd_cfg_if

//--- logic/apd_sel.sv
// Selector that registers the power-down word in force for the mode
`timescale 1ns/1ps
module apd_sel (
    // Clock, reset, enable
    input  wire logic clk_in,
    input  wire logic rst_in,
    input  wire logic ce_in,
    // Configuration words
    apd_cfg_if.sel    cfg
);

    logic [31:0] active_r;
    logic [31:0] active_nxt;

    // Deep sleep replaces the run word; wake returns to it
    always_comb
    begin
        if (cfg.deep_sleep)
        begin
            active_nxt = cfg.deep_cfg & apd_pkg::IMPL_MASK;
        end
        else
        begin
            active_nxt = cfg.run_cfg & apd_pkg::IMPL_MASK;
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            active_r <= apd_pkg::RUN_CFG_RESET;
        end
        else if (ce_in)
        begin
            active_r <= active_nxt;
        end
    end

    assign cfg.active_cfg = active_r;

endmodule : apd_sel

//--- test/apd_checker.sv
// Concurrent checks on the power-down bank ports
`timescale 1ns/1ps
module apd_checker (
    input wire logic        CLK_IN,
    input wire logic        RST_IN,
    input wire logic        CE_IN,
    input wire logic [11:0] ADDR_IN,
    input wire logic [31:0] WDATA_IN,
    input wire logic        WR_IN,
    input wire logic        RD_IN,
    input wire logic [31:0] RDATA_OUT,
    input wire logic        DEEP_SLEEP_IN,
    input wire logic        INTERNAL_OSC_OFF_OUT,
    input wire logic [31:0] POWER_DOWN_OUT,
    input wire logic        CONVERTER_READY_OUT
);
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (RST_IN);

    AST_WO_READ_ZERO:
    assert property (CE_IN && RD_IN && (ADDR_IN == apd_pkg::OFS_RUN_CFG_SET
        || ADDR_IN == apd_pkg::OFS_RUN_CFG_CLEAR) |=> RDATA_OUT == apd_pkg::ZERO_WORD)
        else $error("write-only register read back nonzero");
    AST_RDATA_IDLE:
    assert property (CE_IN && !RD_IN |=> RDATA_OUT == apd_pkg::ZERO_WORD)
        else $error("read data not zero outside read answer");
    AST_OUT_MASKED:
    assert property ((POWER_DOWN_OUT & ~apd_pkg::IMPL_MASK) == apd_pkg::ZERO_WORD)
        else $error("unimplemented power-down bit set");
    AST_OSC_LEVEL:
    assert property (INTERNAL_OSC_OFF_OUT == POWER_DOWN_OUT[4])
        else $error("oscillator level differs from word");
    AST_READY:
    assert property (CONVERTER_READY_OUT == !(POWER_DOWN_OUT[10] || POWER_DOWN_OUT[19]
        || POWER_DOWN_OUT[23]))
        else $error("converter ready wrong");
    AST_RESET_WORD:
    assert property (disable iff (1'b0) RST_IN |=> POWER_DOWN_OUT == apd_pkg::RUN_CFG_RESET
        && RDATA_OUT == apd_pkg::ZERO_WORD)
        else $error("reset word wrong");
    AST_SET_REACHES_OUT:
    assert property (CE_IN && WR_IN && ADDR_IN == apd_pkg::OFS_RUN_CFG_SET && !DEEP_SLEEP_IN
        ##1 CE_IN && !DEEP_SLEEP_IN |=> (POWER_DOWN_OUT & $past(WDATA_IN, 2)
        & apd_pkg::IMPL_MASK) == ($past(WDATA_IN, 2) & apd_pkg::IMPL_MASK))
        else $error("set write not seen at outputs");
    AST_CLEAR_REACHES_OUT:
    assert property (CE_IN && WR_IN && ADDR_IN == apd_pkg::OFS_RUN_CFG_CLEAR && !DEEP_SLEEP_IN
        ##1 CE_IN && !DEEP_SLEEP_IN
        |=> (POWER_DOWN_OUT & $past(WDATA_IN, 2)) == apd_pkg::ZERO_WORD)
        else $error("clear write not seen at outputs");
endmodule : apd_checker

bind apd_top apd_checker apd_checker_i (.CLK_IN, .RST_IN, .CE_IN, .ADDR_IN, .WDATA_IN,
    .WR_IN, .RD_IN, .RDATA_OUT, .DEEP_SLEEP_IN, .INTERNAL_OSC_OFF_OUT, .POWER_DOWN_OUT,
    .CONVERTER_READY_OUT);

//--- test/test_analog_power_down_config.sv
// Self-checking bench for the power-down configuration bank
`timescale 1ns/1ps
module test_analog_power_down_config;
    typedef struct packed {logic [11:0] a; logic [31:0] d; logic [31:0] run;} apd_row_t;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        ce = 1'b1;
    logic        wr_en = 1'b0;
    logic        rd_en = 1'b0;
    logic        deep = 1'b0;
    logic [11:0] addr = 12'h000;
    logic [31:0] wdata = 32'h0000_0000;
    logic [31:0] rdata;
    logic [31:0] pd;
    logic        ready;
    wire  [31:0] offs;
    int          errors = 0;
    int          n_checks = 0;
    apd_row_t    rows [8] = '{
        '{12'h620, 32'h00FB_E5D0, 32'h00FB_E5D0}, '{12'h630, 32'h00FB_E5D0, 32'h0000_0000},
        '{12'h620, 32'h0000_0010, 32'h0000_0010}, '{12'h610, 32'h0080_0000, 32'h0080_0000},
        '{12'h620, 32'h0008_0400, 32'h0088_0400}, '{12'h630, 32'h0080_0000, 32'h0008_0400},
        '{12'h700, 32'hFFFF_FFFF, 32'h0008_0400}, '{12'h640, 32'hFFFF_FFFF, 32'h0008_0400}};

    always #12.5 clk = ~clk;

    apd_top apd_top_i (
        .CLK_IN(clk), .RST_IN(rst), .CE_IN(ce), .ADDR_IN(addr), .WDATA_IN(wdata),
        .WR_IN(wr_en), .RD_IN(rd_en), .RDATA_OUT(rdata), .DEEP_SLEEP_IN(deep),
        .INTERNAL_OSC_OFF_OUT(offs[4]), .TEMP_SENSOR_OFF_OUT(offs[6]),
        .BROWNOUT_RESET_OFF_OUT(offs[7]), .BROWNOUT_IRQ_OFF_OUT(offs[8]),
        .CONVERTER_OFF_OUT(offs[10]), .RAM_BANK_A_OFF_OUT(offs[13]),
        .RAM_BANK_B_OFF_OUT(offs[14]), .RAM_BANK_C_OFF_OUT(offs[15]),
        .RAM_BANK_X_OFF_OUT(offs[16]), .BOOT_ROM_OFF_OUT(offs[17]),
        .CONVERTER_SUPPLY_OFF_OUT(offs[19]), .WATCHDOG_OSC_OFF_OUT(offs[20]),
        .USB_PINS_OFF_OUT(offs[21]), .MAIN_PLL_OFF_OUT(offs[22]),
        .CONVERTER_REFERENCE_OFF_OUT(offs[23]), .POWER_DOWN_OUT(pd),
        .CONVERTER_READY_OUT(ready));

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic bus_wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask : bus_wr

    task automatic bus_rd(input logic [11:0] a, input logic [31:0] exp);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        chk("rdata", exp, rdata);
    endtask : bus_rd

    // Word in force seen on outputs and readiness
    task automatic out_chk(input logic [31:0] exp);
        chk("pd", exp, pd);
        chk("offs", exp, offs & apd_pkg::IMPL_MASK);
        chk("ready", {31'h0000_0000, !(exp[10] | exp[19] | exp[23])}, {31'h0000_0000, ready});
    endtask : out_chk

    task automatic tally_and_finish;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : tally_and_finish

    initial
    begin
        repeat (5000) @(posedge clk);
        errors++;
        tally_and_finish();
    end

    initial
    begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        #1;
        out_chk(apd_pkg::RUN_CFG_RESET);
        bus_rd(apd_pkg::OFS_RUN_CFG, apd_pkg::RUN_CFG_RESET);
        bus_rd(apd_pkg::OFS_DEEP_SLEEP_CFG, apd_pkg::DEEP_CFG_RESET);
        bus_rd(apd_pkg::OFS_RUN_CFG_SET, apd_pkg::ZERO_WORD);
        bus_rd(apd_pkg::OFS_RUN_CFG_CLEAR, apd_pkg::ZERO_WORD);
        bus_rd(12'h700, apd_pkg::ZERO_WORD);
        foreach (rows[i])
        begin
            bus_wr(rows[i].a, rows[i].d);
            bus_rd(apd_pkg::OFS_RUN_CFG, rows[i].run);
            out_chk(rows[i].run);
        end
        bus_wr(apd_pkg::OFS_DEEP_SLEEP_CFG, 32'h0000_0010);
        bus_rd(apd_pkg::OFS_DEEP_SLEEP_CFG, 32'h0000_0010);
        @(posedge clk);
        deep <= 1'b1;
        bus_wr(apd_pkg::OFS_RUN_CFG_SET, 32'h00F0_0000);
        repeat (3) @(posedge clk);
        #1;
        out_chk(32'h0000_0010);
        bus_rd(apd_pkg::OFS_ACTIVE_STATE, 32'h8000_0010);
        @(posedge clk);
        deep <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        out_chk(32'h00F8_0400);
        @(posedge clk);
        ce <= 1'b0;
        bus_wr(apd_pkg::OFS_RUN_CFG_SET, 32'h00FB_E5D0);
        ce <= 1'b1;
        bus_rd(apd_pkg::OFS_RUN_CFG, 32'h00F8_0400);
        @(posedge clk);
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        #1;
        out_chk(apd_pkg::RUN_CFG_RESET);
        bus_rd(apd_pkg::OFS_RUN_CFG, apd_pkg::RUN_CFG_RESET);
        bus_rd(apd_pkg::OFS_DEEP_SLEEP_CFG, apd_pkg::DEEP_CFG_RESET);
        tally_and_finish();
    end
endmodule : test_analog_power_down_config
